//--- hdl/swf_pkg.sv
// Constants shared by both ends of the single-wire function decoder.
// Assumes the byte-level link carried by swf_link_if.
package swf_pkg;

  // ***********************************************
  // Select and function codes
  // ***********************************************
  localparam logic [7:0] CMD_BROADCAST_SEL = 8'hcc;
  localparam logic [7:0] CMD_SHORT_SEL     = 8'h0f;
  localparam logic [7:0] FN_CONVERT        = 8'h44;
  localparam logic [7:0] FN_WR_REGS        = 8'h4e;
  localparam logic [7:0] FN_RD_REGS        = 8'hbe;
  localparam logic [7:0] FN_COPY_REGS      = 8'h48;
  localparam logic [7:0] FN_WR_MEM         = 8'h0f;
  localparam logic [7:0] FN_RD_MEM         = 8'haa;
  localparam logic [7:0] FN_COMMIT_MEM     = 8'h55;
  localparam logic [7:0] FN_RD_EEPROM      = 8'hf0;
  localparam logic [7:0] FN_GPIO_WR        = 8'ha5;
  localparam logic [7:0] COMMIT_KEY        = 8'ha5;
  localparam logic [7:0] GPIO_OK           = 8'haa;
  localparam logic [7:0] IDLE_BYTE         = 8'hff;

  // ***********************************************
  // Register scratchpad layout
  // ***********************************************
  localparam int         SP1_BYTES     = 16;
  localparam int         SP1_CFG1      = 4;
  localparam int         SP1_CFG2      = 5;
  localparam int         SP1_SHORT     = 6;
  localparam int         SP1_WR_BYTES  = 9;
  localparam int         SP1_BLOCK     = 8;
  localparam int         AUTO_CONV_BIT = 0;
  localparam int         LOCK_BIT      = 1;
  localparam logic [7:0] FAST_LOCK_MSK = 8'h03;
  localparam logic [7:0] SHORT_MODE_MSK = 8'hc0;
  localparam logic [7:0] SP1_RST [SP1_BYTES] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff,
                                                 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};

  // ***********************************************
  // Memory scratchpad and EEPROM
  // ***********************************************
  localparam int MEM_BLOCK    = 8;
  localparam int MEM_WR_BYTES = 10;
  localparam int EE_DEPTH_DEF = 256;

  // ***********************************************
  // Host command registers
  // ***********************************************
  localparam logic [3:0] HREG_CMD     = 4'h0;
  localparam logic [3:0] HREG_STATUS  = 4'h4;
  localparam logic [1:0] OP_RESET     = 2'h0;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_IDLE      = 2'h3;
  localparam int         IDLE_UNIT_NS = 1000;
  localparam int         CLK_NS       = 10;
  localparam int         IDLE_UNIT_CYC = (IDLE_UNIT_NS + CLK_NS - 1) / CLK_NS;

  // Reflected CRC-8, polynomial x^8+x^5+x^4+1, one byte LSB first.
  function automatic logic [7:0] swf_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    logic       mix;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      mix = c[0] ^ data[i];
      c   = {1'b0, c[7:1]} ^ (mix ? 8'h8c : 8'h00);
    end
    return c;
  endfunction : swf_crc8

endpackage : swf_pkg

//--- hdl/swf_link_if.sv
// Byte-level link between the bus host and the function decoder.
// Assumes one shared clock; every strobe is a one-cycle pulse.
`timescale 1ns/1ps
interface swf_link_if;
  logic       bus_rst;
  logic       wr_stb;
  logic [7:0] wr_byte;
  logic       rd_stb;
  logic       rd_ack;
  logic [7:0] rd_byte;

  modport dev  (input bus_rst, wr_stb, wr_byte, rd_stb, output rd_ack, rd_byte);
  modport host (output bus_rst, wr_stb, wr_byte, rd_stb, input rd_ack, rd_byte);
endinterface : swf_link_if

//--- hdl/swf_device.sv
// Device end: function-phase command interpreter with scratchpads and EEPROM.
// Assumes the host keeps its idle periods and pulses bus_rst before each select.
`timescale 1ns/1ps
module swf_device import swf_pkg::*; #(
  parameter int EE_DEPTH = EE_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Link to host
  swf_link_if.dev         link,
  // Sensor core
  input  wire logic       conv_done_in,
  input  wire logic [7:0] temp_lo_in,
  input  wire logic [7:0] temp_hi_in,
  input  wire logic [7:0] status_in,
  // Controls and status
  output logic            conv_start_out,
  output logic            cfg_store_out,
  output logic            ee_prog_out,
  output logic            selected_out,
  output logic            fast_speed_enable_out,
  output logic            lock_out,
  output logic [7:0]      io_cfg_out
);

  localparam int AW = $clog2(EE_DEPTH);

  if (EE_DEPTH < MEM_BLOCK || EE_DEPTH > 65536 || (1 << AW) != EE_DEPTH) begin : g_chk
    $error("EE_DEPTH must be a power of two from 8 to 65536");
  end

  typedef enum logic [3:0] {
    ST_ADDR, ST_SHORT, ST_FUNC, ST_W1, ST_W1_CRC, ST_R1, ST_W2, ST_W2_CRC,
    ST_R2A, ST_R2D, ST_CP2, ST_EEA, ST_EED, ST_IO, ST_IO_ANS, ST_DEAD
  } swf_dev_state_e;

  swf_dev_state_e state;
  logic [7:0]     sp1 [SP1_BYTES];
  logic [7:0]     mem_buf [MEM_BLOCK];
  logic [7:0]     ee [EE_DEPTH];
  logic [4:0]     cnt;
  logic [7:0]     crc;
  logic [7:0]     tmp_lo;
  logic [7:0]     pend;
  logic [7:0]     io_ans;
  logic [15:0]    mem_addr;
  logic [16:0]    ptr;
  logic [7:0]     tx_byte;
  logic           keep_short;

  // ***********************************************
  // Decoding
  // ***********************************************
  wire logic       wr        = link.wr_stb;
  wire logic       rd        = link.rd_stb;
  wire logic [7:0] b         = link.wr_byte;
  wire logic       locked    = sp1[SP1_CFG2][LOCK_BIT];
  wire logic       auto_conv = sp1[SP1_CFG1][AUTO_CONV_BIT];
  wire logic       short_fix = (sp1[SP1_CFG1] & SHORT_MODE_MSK) != 8'h00;
  wire logic       ee_ok     = ptr < 17'(EE_DEPTH);
  wire logic [4:0] w1_idx    = (cnt < 5'd3) ? cnt + 5'd4 : cnt + 5'd5;
  wire logic [2:0] r1_idx    = (cnt < 5'd8) ? cnt[2:0] : 3'(cnt - 5'd9);
  wire logic [7:0] r1_byte   = sp1[{(cnt > 5'd8), r1_idx}];
  wire logic       r1_crc    = (cnt == 5'd8) || (cnt == 5'd17);
  wire logic [7:0] next_crc_w = swf_crc8(crc, b);
  wire logic [7:0] next_crc_r = swf_crc8(crc, tx_byte);

  always_comb begin
    tx_byte = IDLE_BYTE;
    case (state)
      ST_W1_CRC, ST_W2_CRC: tx_byte = crc;
      ST_R1:     tx_byte = r1_crc ? crc : ((cnt < 5'd17) ? r1_byte : IDLE_BYTE);
      ST_R2D:    tx_byte = (cnt < 5'd8) ? mem_buf[cnt[2:0]] : crc;
      ST_EED:    tx_byte = ee_ok ? ee[ptr[AW-1:0]] : IDLE_BYTE;
      ST_IO_ANS: tx_byte = io_ans;
      default:   tx_byte = IDLE_BYTE;
    endcase
  end

  // ***********************************************
  // Command sequencer
  // ***********************************************
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state <= ST_ADDR;
      cnt <= 5'd0;
      crc <= 8'h00;
      tmp_lo <= 8'h00;
      pend <= 8'h00;
      io_ans <= IDLE_BYTE;
      mem_addr <= 16'h0000;
      ptr <= 17'h00000;
      link.rd_ack <= 1'b0;
      link.rd_byte <= IDLE_BYTE;
      conv_start_out <= 1'b0;
      cfg_store_out <= 1'b0;
      ee_prog_out <= 1'b0;
      selected_out <= 1'b0;
      io_cfg_out <= 8'h00;
      fast_speed_enable_out <= 1'b0;
      lock_out <= 1'b0;
      keep_short <= 1'b0;
      for (int i = 0; i < SP1_BYTES; i++) sp1[i] <= SP1_RST[i];
      for (int i = 0; i < MEM_BLOCK; i++) mem_buf[i] <= 8'h00;
    end else begin
      conv_start_out <= 1'b0;
      cfg_store_out <= 1'b0;
      ee_prog_out <= 1'b0;
      link.rd_ack <= rd;
      link.rd_byte <= rd ? tx_byte : IDLE_BYTE;
      if (conv_done_in) begin
        sp1[0] <= temp_lo_in;
        sp1[1] <= temp_hi_in;
        sp1[2] <= status_in;
      end
      if (link.bus_rst) begin
        state <= ST_ADDR;
        selected_out <= 1'b0;
        cnt <= 5'd0;
        crc <= 8'h00;
      end else begin
        case (state)
          ST_ADDR: if (wr) begin
            if (b == CMD_BROADCAST_SEL) begin
              state <= ST_FUNC;
              selected_out <= 1'b1;
            end else if (b == CMD_SHORT_SEL) state <= ST_SHORT;
            else state <= ST_DEAD;
          end
          ST_SHORT: if (wr) begin
            state <= (b == sp1[SP1_SHORT]) ? ST_FUNC : ST_DEAD;
            selected_out <= (b == sp1[SP1_SHORT]);
          end
          ST_FUNC: if (wr) begin
            cnt <= 5'd0;
            crc <= 8'h00;
            case (b)
              FN_CONVERT: begin
                conv_start_out <= !auto_conv;
                state <= ST_DEAD;
              end
              FN_WR_REGS: begin
                // Mode is taken before this write, so the write that sets it still stores its short byte.
                keep_short <= short_fix;
                state <= ST_W1;
              end
              FN_RD_REGS:    state <= ST_R1;
              FN_COPY_REGS: begin
                cfg_store_out <= 1'b1;
                state <= ST_DEAD;
              end
              FN_WR_MEM:     state <= ST_W2;
              FN_RD_MEM:     state <= ST_R2A;
              FN_COMMIT_MEM: state <= ST_CP2;
              FN_RD_EEPROM:  state <= ST_EEA;
              FN_GPIO_WR:    state <= ST_IO;
              default:       state <= ST_DEAD;
            endcase
          end
          ST_W1: if (wr) begin
            crc <= next_crc_w;
            cnt <= cnt + 5'd1;
            if (cnt == 5'(SP1_WR_BYTES - 1)) state <= ST_W1_CRC;
            if (cnt == 5'd1) begin
              pend <= locked ? (sp1[SP1_CFG2] & FAST_LOCK_MSK) : (b & FAST_LOCK_MSK);
              if (!locked) sp1[SP1_CFG2] <= (b & ~FAST_LOCK_MSK) | (sp1[SP1_CFG2] & FAST_LOCK_MSK);
            end else if (!locked && !(cnt == 5'd2 && keep_short)) begin
              sp1[w1_idx[3:0]] <= b;
            end
          end
          ST_W1_CRC: if (rd) begin
            sp1[SP1_CFG2] <= (sp1[SP1_CFG2] & ~FAST_LOCK_MSK) | pend;
            state <= ST_DEAD;
          end
          ST_R1: if (rd) begin
            if (cnt != 5'd18) cnt <= cnt + 5'd1;
            crc <= r1_crc ? 8'h00 : next_crc_r;
          end
          ST_W2: if (wr) begin
            crc <= next_crc_w;
            cnt <= cnt + 5'd1;
            if (cnt == 5'd0) mem_addr[7:0] <= b;
            else if (cnt == 5'd1) mem_addr[15:8] <= b;
            else mem_buf[3'(cnt - 5'd2)] <= b;
            if (cnt == 5'(MEM_WR_BYTES - 1)) state <= ST_W2_CRC;
          end
          ST_W2_CRC: if (rd) state <= ST_DEAD;
          ST_R2A: if (wr) begin
            crc <= next_crc_w;
            cnt <= cnt + 5'd1;
            tmp_lo <= b;
            if (cnt == 5'd1) begin
              state <= ({b, tmp_lo} == mem_addr) ? ST_R2D : ST_DEAD;
              cnt <= 5'd0;
            end
          end
          ST_R2D: if (rd) begin
            crc <= next_crc_r;
            cnt <= cnt + 5'd1;
            if (cnt == 5'd8) state <= ST_DEAD;
          end
          ST_CP2: if (wr) begin
            ee_prog_out <= (b == COMMIT_KEY);
            state <= ST_DEAD;
          end
          ST_EEA: if (wr) begin
            cnt <= cnt + 5'd1;
            tmp_lo <= b;
            if (cnt == 5'd1) begin
              ptr <= {1'b0, b, tmp_lo[7:3], 3'b000};
              state <= ST_EED;
            end
          end
          ST_EED: if (rd && ee_ok) ptr <= ptr + 17'd1;
          ST_IO: if (wr) begin
            cnt <= cnt + 5'd1;
            tmp_lo <= b;
            if (cnt == 5'd1) begin
              io_ans <= (b == ~tmp_lo) ? GPIO_OK : IDLE_BYTE;
              if (b == ~tmp_lo) io_cfg_out <= tmp_lo;
              state <= ST_IO_ANS;
            end
          end
          ST_IO_ANS: if (rd) state <= ST_DEAD;
          default: ;
        endcase
      end
      fast_speed_enable_out <= sp1[SP1_CFG2][0];
      lock_out <= sp1[SP1_CFG2][LOCK_BIT];
    end
  end

  // ***********************************************
  // User EEPROM
  // ***********************************************
  // Cells hold no reset value, as a real array would not.
  always_ff @(posedge clk_in) begin
    // unaligned write lands at raw address
    if (ee_prog_out) begin
      for (int i = 0; i < MEM_BLOCK; i++) ee[AW'(mem_addr[AW-1:0] + AW'(i))] <= mem_buf[i];
    end
  end

endmodule : swf_device

//--- hdl/swf_host.sv
// Host end: byte engine ordered by software over Avalon-MM.
// Assumes software builds each select and function sequence from these primitives.
`timescale 1ns/1ps
module swf_host import swf_pkg::*; #(
  parameter int IDLE_UNIT = IDLE_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Link to device
  swf_link_if.host         link
);

  if (IDLE_UNIT < 1 || IDLE_UNIT > 65535) begin : g_chk
    $error("IDLE_UNIT must be 1 to 65535");
  end

  typedef enum logic [1:0] {H_IDLE, H_WAIT_ACK, H_COUNT} swf_host_state_e;

  swf_host_state_e hs;
  logic [31:0]     idle_cnt;
  logic [7:0]      rx_byte;

  // ***********************************************
  // Bus decode
  // ***********************************************
  wire logic        busy       = hs != H_IDLE;
  wire logic        next_wait  = !(avs_waitrequest && (avs_read || (avs_write && !busy)));
  wire logic        exec       = !avs_waitrequest && avs_write && avs_address == HREG_CMD;
  wire logic [1:0]  op         = avs_writedata[1:0];
  wire logic [31:0] idle_total = 32'(avs_writedata[31:16]) * 32'(IDLE_UNIT);
  wire logic [31:0] status_word = {16'h0000, rx_byte, 7'h00, busy};

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      hs <= H_IDLE;
      idle_cnt <= 32'h0;
      rx_byte <= IDLE_BYTE;
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
      link.bus_rst <= 1'b0;
      link.wr_stb <= 1'b0;
      link.wr_byte <= 8'h00;
      link.rd_stb <= 1'b0;
    end else begin
      avs_waitrequest <= next_wait;
      link.bus_rst <= 1'b0;
      link.wr_stb <= 1'b0;
      link.rd_stb <= 1'b0;
      if (avs_waitrequest && avs_read) avs_readdata <= (avs_address == HREG_STATUS) ? status_word : 32'h0;
      case (hs)
        H_IDLE: if (exec) begin
          case (op)
            OP_RESET: link.bus_rst <= 1'b1;
            OP_WRITE: begin
              link.wr_stb <= 1'b1;
              link.wr_byte <= avs_writedata[15:8];
            end
            OP_READ: begin
              link.rd_stb <= 1'b1;
              hs <= H_WAIT_ACK;
            end
            default: if (idle_total != 32'h0) begin
              idle_cnt <= idle_total;
              hs <= H_COUNT;
            end
          endcase
        end
        H_WAIT_ACK: if (link.rd_ack) begin
          rx_byte <= link.rd_byte;
          hs <= H_IDLE;
        end
        H_COUNT: begin
          idle_cnt <= idle_cnt - 32'd1;
          if (idle_cnt == 32'd1) hs <= H_IDLE;
        end
        default: hs <= H_IDLE;
      endcase
    end
  end

endmodule : swf_host

//--- tb/swf_link_monitor.sv
// Concurrent checks on the byte link between host and device.
// Assumes one clock; every link strobe is a one-cycle pulse.
`timescale 1ns/1ps
module swf_link_monitor import swf_pkg::*; (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  // Link signals
  input wire logic       bus_rst,
  input wire logic       wr_stb,
  input wire logic [7:0] wr_byte,
  input wire logic       rd_stb,
  input wire logic       rd_ack,
  input wire logic [7:0] rd_byte
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // ****
  // Frame tracking since the last bus reset
  // ****
  logic [3:0] wcnt;
  logic [4:0] rcnt;
  logic [7:0] b [4];
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || bus_rst) begin
      wcnt <= '0;
      rcnt <= '0;
    end else begin
      if (wr_stb && wcnt < 4'h4) b[wcnt[1:0]] <= wr_byte;
      if (wr_stb && wcnt != 4'hf) wcnt <= wcnt + 4'h1;
      if (rd_ack && rcnt != 5'h1f) rcnt <= rcnt + 5'h01;
    end
  end
  wire cc  = wcnt >= 4'h2 && b[0] == CMD_BROADCAST_SEL;
  wire gp  = cc && b[1] == FN_GPIO_WR && wcnt == 4'h4 && rcnt == 5'h00;
  wire unk = cc && !(b[1] inside {FN_CONVERT, FN_WR_REGS, FN_RD_REGS, FN_COPY_REGS, FN_WR_MEM,
                                  FN_RD_MEM, FN_COMMIT_MEM, FN_RD_EEPROM, FN_GPIO_WR});
  wire bad_sel = wcnt >= 4'h1 && b[0] != CMD_BROADCAST_SEL && b[0] != CMD_SHORT_SEL;
  // Reserved scratchpad bytes and the tail after the second check byte read as ones.
  wire rsv = cc && b[1] == FN_RD_REGS && wcnt == 4'h2 &&
             (rcnt inside {5'd3, 5'd7, 5'd15, 5'd16} || rcnt > 5'd17);

  ack_follows_a: assert property (rd_stb |=> rd_ack ##1 (!rd_ack || $past(rd_stb)))
    else $error("read slot not answered once");
  ack_cause_a:   assert property (rd_ack |-> $past(rd_stb))
    else $error("answer without read slot");
  idle_ones_a:   assert property (!rd_ack |-> rd_byte == IDLE_BYTE)
    else $error("read byte not ones between answers");
  gpio_ok_a:     assert property (rd_ack && gp && b[3] == ~b[2] |-> rd_byte == GPIO_OK)
    else $error("io config accepted code wrong");
  gpio_bad_a:    assert property (rd_ack && gp && b[3] != ~b[2] |-> rd_byte == IDLE_BYTE)
    else $error("io config fail code wrong");
  unk_fn_a:      assert property (rd_ack && unk |-> rd_byte == IDLE_BYTE)
    else $error("unknown function answered");
  bad_sel_a:     assert property (rd_ack && bad_sel |-> rd_byte == IDLE_BYTE)
    else $error("unselected device answered");
  reg_rsvd_a:    assert property (rd_ack && rsv |-> rd_byte == IDLE_BYTE)
    else $error("reserved register byte not ones");

  cover property (rd_ack && gp);
  cover property (rd_ack && unk);
  cover property (rd_ack && rsv);
  cover property (rd_ack && bad_sel);
endmodule : swf_link_monitor

//--- tb/tb_single_wire_function_decoder.sv
// Bench joining host and device; software orders reach the host over Avalon-MM.
// Assumes the host status register reports busy and the last read byte.
`timescale 1ns/1ps
module tb_single_wire_function_decoder import swf_pkg::*;;
  logic        clk_in, rst_b_in, avs_read, avs_write, avs_waitrequest, conv_done_in;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, t;
  logic [7:0]  temp_lo_in, temp_hi_in, status_in, io_cfg_out, g, cr, x;
  logic        conv_start_out, cfg_store_out, ee_prog_out, selected_out, fast_speed_enable_out, lock_out;
  logic [7:0]  sp [16];
  logic [7:0]  v [9];
  logic [7:0]  d [8];
  int          fails = 0, compares = 0, n_conv = 0, n_cfg = 0, n_ee = 0, k;

  swf_link_if link();
  swf_host #(.IDLE_UNIT(1)) i_swf_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link.host));
  swf_device #(.EE_DEPTH(256)) i_swf_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link.dev),
    .conv_done_in(conv_done_in), .temp_lo_in(temp_lo_in), .temp_hi_in(temp_hi_in), .status_in(status_in),
    .conv_start_out(conv_start_out), .cfg_store_out(cfg_store_out), .ee_prog_out(ee_prog_out),
    .selected_out(selected_out), .fast_speed_enable_out(fast_speed_enable_out), .lock_out(lock_out),
    .io_cfg_out(io_cfg_out));
  swf_link_monitor i_swf_link_monitor (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_rst(link.bus_rst),
    .wr_stb(link.wr_stb), .wr_byte(link.wr_byte), .rd_stb(link.rd_stb), .rd_ack(link.rd_ack),
    .rd_byte(link.rd_byte));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    n_conv += int'(conv_start_out === 1'b1);
    n_cfg  += int'(cfg_store_out === 1'b1);
    n_ee   += int'(ee_prog_out === 1'b1);
  end

  // ****
  // Model helpers and compares
  // ****
  function automatic logic [7:0] m_crc(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction : m_crc
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic print_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // ****
  // Bus and link primitives
  // ****
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_in);
    avs_address <= a; avs_write <= w; avs_read <= !w; avs_writedata <= wd;
    do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0; avs_read <= 1'b0;
  endtask : av
  task automatic op(input logic [31:0] cmd, output logic [7:0] b);
    logic [31:0] s;
    av(HREG_CMD, 1'b1, cmd, s);
    do av(HREG_STATUS, 1'b0, 32'h0, s); while (s[0] !== 1'b0);
    b = s[15:8];
  endtask : op
  task automatic lw(input logic [7:0] b); op({16'h0, b, 6'h0, OP_WRITE}, x); endtask : lw
  task automatic lrst; op({30'h0, OP_RESET}, x); endtask : lrst
  task automatic lidle; op({16'h0004, 14'h0, OP_IDLE}, x); endtask : lidle
  task automatic rc(input logic [7:0] e); op({30'h0, OP_READ}, g); chk_byte(g, e); endtask : rc
  task automatic sel(input logic [7:0] fn); lrst(); lw(CMD_BROADCAST_SEL); lw(fn); endtask : sel
  task automatic newv;
    foreach (v[i]) v[i] = 8'($urandom);
    v[0] &= 8'h3e;
    v[1] &= 8'hfc;
  endtask : newv
  task automatic wsp(input bit full);
    sel(FN_WR_REGS);
    cr = 8'h00;
    foreach (v[i]) begin lw(v[i]); cr = m_crc(cr, v[i]); end
    if (full) rc(cr);
    // A locked scratchpad keeps every byte.
    if (full && !sp[SP1_CFG2][LOCK_BIT]) begin
      if (sp[SP1_CFG1][7:6] == 2'b00) sp[SP1_SHORT] = v[2];
      sp[SP1_CFG1] = v[0];
      sp[SP1_CFG2] = v[1];
      for (int i = 0; i < 6; i++) sp[8 + i] = v[3 + i];
    end
  endtask : wsp
  task automatic rsp;
    sel(FN_RD_REGS);
    cr = 8'h00;
    for (int i = 0; i < 16; i++) begin
      rc(sp[i]);
      cr = m_crc(cr, sp[i]);
      if (i % 8 == 7) begin rc(cr); cr = 8'h00; end
    end
    rc(IDLE_BYTE);
  endtask : rsp
  task automatic pulses(input int was, input int now, input logic [7:0] e);
    repeat (4) @(posedge clk_in);
    chk_byte(8'(now - was), e);
  endtask : pulses

  initial begin
    #200_000;
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    rst_b_in = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0; avs_writedata = 32'h0;
    conv_done_in = 1'b0; temp_lo_in = 8'h00; temp_hi_in = 8'h00; status_in = 8'h00;
    void'($urandom(32'h4974d883));
    sp = SP1_RST;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    av(4'hc, 1'b0, 32'h0, q);
    chk_byte(q[7:0], 8'h00);
    newv(); wsp(1); rsp(); $display("end regs");
    newv(); v[1][0] = 1'b1; wsp(0); lrst();
    repeat (2) @(posedge clk_in); chk_bit(fast_speed_enable_out, 1'b0);
    wsp(1); repeat (2) @(posedge clk_in); chk_bit(fast_speed_enable_out, 1'b1);
    chk_bit(lock_out, 1'b0);
    k = n_conv; sel(FN_CONVERT); pulses(k, n_conv, 8'h01);
    t = $urandom; lidle();
    @(posedge clk_in); temp_lo_in <= t[7:0]; temp_hi_in <= t[15:8]; status_in <= t[23:16]; conv_done_in <= 1'b1;
    @(posedge clk_in); conv_done_in <= 1'b0;
    sp[0] = t[7:0]; sp[1] = t[15:8]; sp[2] = t[23:16]; rsp();
    newv(); v[0][0] = 1'b1; wsp(1);
    k = n_conv; sel(FN_CONVERT); pulses(k, n_conv, 8'h00);
    newv(); wsp(1);
    k = n_cfg; sel(FN_COPY_REGS); pulses(k, n_cfg, 8'h01); lidle();
    lrst(); lw(CMD_SHORT_SEL); lw(sp[SP1_SHORT]); lw(FN_RD_REGS); rc(sp[0]);
    chk_bit(selected_out, 1'b1);
    lrst(); lw(CMD_SHORT_SEL); lw(sp[SP1_SHORT] + 8'h01); lw(FN_RD_REGS); rc(IDLE_BYTE);
    chk_bit(selected_out, 1'b0);
    for (int j = 0; j < 3; j++) begin
      newv(); v[0][6] = (j < 2); wsp(1); lidle();
    end
    rsp(); $display("end select");
    sel(FN_WR_MEM); lw(8'hf8); lw(8'h00);
    cr = m_crc(m_crc(8'h00, 8'hf8), 8'h00);
    foreach (d[i]) begin d[i] = 8'($urandom); lw(d[i]); cr = m_crc(cr, d[i]); end
    rc(cr);
    sel(FN_RD_MEM); lw(8'hf8); lw(8'h00);
    cr = m_crc(m_crc(8'h00, 8'hf8), 8'h00);
    foreach (d[i]) begin rc(d[i]); cr = m_crc(cr, d[i]); end
    rc(cr);
    k = n_ee; sel(FN_COMMIT_MEM); lw(COMMIT_KEY); pulses(k, n_ee, 8'h01); lidle();
    k = n_ee; sel(FN_COMMIT_MEM); lw(8'h00); pulses(k, n_ee, 8'h00);
    sel(FN_RD_EEPROM); lw(8'hfb); lw(8'h00); lidle();
    foreach (d[i]) rc(d[i]);
    repeat (2) rc(IDLE_BYTE);
    sel(FN_RD_MEM); lw(8'hf0); lw(8'h00);
    repeat (9) rc(IDLE_BYTE);
    $display("end memory");
    for (int j = 0; j < 2; j++) begin
      t = $urandom; sel(FN_GPIO_WR); lw(t[7:0]); lw(j == 0 ? ~t[7:0] : t[7:0] ^ 8'h01);
      rc(j == 0 ? GPIO_OK : IDLE_BYTE);
      if (j == 0) chk_byte(io_cfg_out, t[7:0]);
    end
    sel(8'h77); rc(IDLE_BYTE);
    lrst(); lw(8'h5a); rc(IDLE_BYTE);
    chk_bit(selected_out, 1'b0);
    $display("end io");
    newv(); v[1][1] = 1'b1; wsp(1);
    repeat (2) @(posedge clk_in); chk_bit(lock_out, 1'b1);
    newv(); wsp(1); rsp();
    @(posedge clk_in); rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in); rst_b_in <= 1'b1;
    sp = SP1_RST; rsp();
    chk_bit(lock_out, 1'b0);
    $display("end lock");
    print_verdict();
  end
endmodule : tb_single_wire_function_decoder
